// file: inc/sst_consts.svh
// Register offsets, field widths, reset values and counts of the synchronous serial port
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
`define SST_AW 8
`define SST_OFF_TX_CTRL 8'h00
`define SST_OFF_RX_CTRL 8'h04
`define SST_OFF_RATE_CTRL 8'h08
`define SST_OFF_DIV_LOW 8'h0c
`define SST_OFF_DIV_HIGH 8'h10
`define SST_OFF_TX_BUF 8'h14
`define SST_OFF_RX_DATA 8'h18
`define SST_WORD_MASK 8'hfc
`define SST_TXC_W 5
`define SST_RXC_W 3
`define SST_RTC_W 3
`define SST_BYTE_W 8
`define SST_CHAR_W 9
`define SST_LAST_BIT8 4'h7
`define SST_LAST_BIT9 4'h8
`define SST_BITS8 4'h8
`define SST_BITS9 4'h9
`define SST_RESP_OKAY 2'b00
`define SST_RESP_SLVERR 2'b10
`define SST_DIV_RESET 8'h00
`endif

// file: inc/sst_pkg.sv
// Types shared by the synchronous serial port files
package sst_pkg;
    typedef enum logic {
        SST_IDLE = 1'b0,
        SST_SHIFT = 1'b1
    } sst_state_t;

    // Transmit control register, lowest field in bit 0
    typedef struct packed {
        logic ninth_data_bit;
        logic ninth_bit_enable;
        logic transmit_enable;
        logic clock_source_master;
        logic clocked_mode;
    } sst_tx_ctrl_t;

    // Receive control register
    typedef struct packed {
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic serial_port_enable;
    } sst_rx_ctrl_t;

    // Bit rate control register
    typedef struct packed {
        logic wide_divider_select;
        logic high_speed_divider;
        logic clock_polarity_select;
    } sst_rate_ctrl_t;
endpackage

// file: rtl/sst_sync2.sv
// Two-flop synchroniser for the clock and data pin inputs
`timescale 1ns/1ns
module sst_sync2 (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] meta_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_r <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// file: rtl/sst_baud_gen.sv
// Baud divider giving a one-cycle tick per half bit of the master clock
`timescale 1ns/1ns
`include "sst_consts.svh"
module sst_baud_gen (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic wide_in,
    input wire logic [15:0] div_in,
    output logic tick_out
);
    logic [15:0] cnt_r;
    logic [15:0] limit;

    // Narrow mode ignores the high divider byte
    assign limit = wide_in ? div_in : {`SST_DIV_RESET, div_in[7:0]};
    assign tick_out = run_in && (cnt_r == limit);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run_in || tick_out) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule

// file: rtl/sst_sync_serial.sv
// Synchronous serial port: master and slave, AXI4-Lite register slave
// What this block does
// - One shared data line: drive it or listen to it, never both.
// - Characters carry data bits only, no start or stop bits.
// - Clocked mode selects synchronous operation; clock source bit makes it master.
// - Both receive enables clear means transmit; either set means receive.
// - The port works only while the serial port enable is set.
// - Master drives the clock pin; its driver enables when transmit or receive set.
// - One clock per data bit, no extra clocks.
// - Data changes on the leading edge, stable through the trailing edge.
// - Polarity set: clock idles high, data changes on falling edges.
// - Polarity clear: clock idles low, data changes on rising edges.
// - Master transmit drives data on data pin, both pin drivers enabled.
// - Buffer write starts a send; it waits while the shifter is busy.
// - Empty shifter takes the buffered byte at once and starts shifting.
// - The shift register is hidden from software.
// - Ninth-bit enable sends nine bits; ninth bit is loaded before the byte.
// - As slave the port shifts with the clock supplied by the master.
`timescale 1ns/1ns
`include "sst_consts.svh"
module sst_sync_serial (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic clock_pin_in,
    output logic clock_pin_out,
    output logic clock_pin_oe_out,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_out
);
    sst_pkg::sst_tx_ctrl_t txc_r;
    sst_pkg::sst_rx_ctrl_t rxc_r;
    sst_pkg::sst_rate_ctrl_t rtc_r;
    sst_pkg::sst_state_t state_r;
    logic [7:0] div_low_r, div_high_r, hold_r, rx_data_r;
    logic hold_full_r, rx_ready_r, rx_ninth_r;
    logic [8:0] shift_r, rx_shift_r, rx_next;
    logic [3:0] bit_cnt_r, frame_edges_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [1:0] pins_s;
    logic clk_s_d_r;
    logic do_wr, wr_lane0, rd_take, buf_write, rx_read;
    logic [7:0] woff, roff;
    logic sync_on, rx_mode, tx_mode, master, pol;
    logic tick, lead_ev, trail_ev, last_bit, start_tx, start_rx, rx_done;
    logic ext_edge, clk_s, data_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs and rate divider

    sst_sync2 i_sst_sync2 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({clock_pin_in, data_pin_in}),
        .sync_out(pins_s)
    );
    assign clk_s = pins_s[1];
    assign data_s = pins_s[0];

    sst_baud_gen i_sst_baud_gen (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .run_in(master && state_r == sst_pkg::SST_SHIFT),
        .wide_in(rtc_r.wide_divider_select),
        .div_in({div_high_r, div_low_r}),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    assign sync_on = txc_r.clocked_mode && rxc_r.serial_port_enable;
    assign master = txc_r.clock_source_master;
    assign rx_mode = rxc_r.single_receive_enable || rxc_r.continuous_receive_enable;
    assign tx_mode = sync_on && txc_r.transmit_enable && !rx_mode;
    assign pol = rtc_r.clock_polarity_select;

    // Slave edges come from the synchronised pin, so they lag the wire by two cycles
    assign ext_edge = clk_s != clk_s_d_r;
    always_comb begin
        if (state_r != sst_pkg::SST_SHIFT) begin
            lead_ev = 1'b0;
            trail_ev = 1'b0;
        end else if (master) begin
            lead_ev = tick && (clock_pin_out == pol);
            trail_ev = tick && (clock_pin_out != pol);
        end else begin
            lead_ev = ext_edge && (clk_s != pol);
            trail_ev = ext_edge && (clk_s == pol);
        end
    end

    assign last_bit = bit_cnt_r == (txc_r.ninth_bit_enable ? `SST_LAST_BIT9 : `SST_LAST_BIT8);
    assign start_tx = state_r == sst_pkg::SST_IDLE && tx_mode && hold_full_r;
    assign start_rx = state_r == sst_pkg::SST_IDLE && sync_on && rx_mode;
    assign rx_done = trail_ev && last_bit && rx_mode;
    assign rx_next = {data_s, rx_shift_r[8:1]};

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    assign clock_pin_oe_out = sync_on && master && (txc_r.transmit_enable || rx_mode);
    assign data_pin_oe_out = tx_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift engine

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !sync_on) begin
            state_r <= sst_pkg::SST_IDLE;
        end else begin
            case (state_r)
                sst_pkg::SST_IDLE: begin
                    if (start_tx || start_rx) begin
                        state_r <= sst_pkg::SST_SHIFT;
                    end
                end
                sst_pkg::SST_SHIFT: begin
                    if (trail_ev && last_bit) begin
                        state_r <= sst_pkg::SST_IDLE;
                    end
                end
                default: begin
                    state_r <= sst_pkg::SST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r == sst_pkg::SST_IDLE) begin
            bit_cnt_r <= 4'h0;
        end else if (trail_ev) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Idle level follows the polarity select at all times outside a frame
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clock_pin_out <= 1'b0;
        end else if (state_r == sst_pkg::SST_IDLE || !sync_on) begin
            clock_pin_out <= pol;
        end else if (master && tick) begin
            clock_pin_out <= !clock_pin_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clk_s_d_r <= 1'b0;
        end else begin
            clk_s_d_r <= clk_s;
        end
    end

    // No framing bits: the line carries the character bits alone
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            shift_r <= 9'h000;
            data_pin_out <= 1'b0;
        end else if (start_tx) begin
            shift_r <= {txc_r.ninth_data_bit, hold_r};
        end else if (lead_ev && tx_mode) begin
            data_pin_out <= shift_r[0];
            shift_r <= {1'b0, shift_r[8:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Holding buffer and receive capture

    // A write landing on the transfer cycle keeps the buffer full: set wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hold_full_r <= 1'b0;
            hold_r <= 8'h00;
        end else if (buf_write) begin
            hold_full_r <= 1'b1;
            hold_r <= wdata_r[7:0];
        end else if (start_tx) begin
            hold_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_shift_r <= 9'h000;
            rx_data_r <= 8'h00;
            rx_ninth_r <= 1'b0;
        end else if (trail_ev && rx_mode) begin
            rx_shift_r <= rx_next;
            if (last_bit) begin
                rx_data_r <= txc_r.ninth_bit_enable ? rx_next[7:0] : rx_next[8:1];
                rx_ninth_r <= txc_r.ninth_bit_enable && rx_next[8];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_ready_r <= 1'b0;
        end else if (rx_done) begin
            rx_ready_r <= 1'b1;
        end else if (rx_read) begin
            rx_ready_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = !w_held_r && !bvalid_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign do_wr = aw_held_r && w_held_r && !bvalid_r;
    assign woff = waddr_r & `SST_WORD_MASK;
    assign wr_lane0 = do_wr && wstrb_r[0];
    assign buf_write = wr_lane0 && woff == `SST_OFF_TX_BUF;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (do_wr) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_r <= 1'b1;
                waddr_r <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bvalid_r <= 1'b0;
            bresp_r <= `SST_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            if (woff <= `SST_OFF_TX_BUF) begin
                bresp_r <= `SST_RESP_OKAY;
            end else begin
                bresp_r <= `SST_RESP_SLVERR;
            end
        end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
        end
    end

    // Hardware clears single receive after one master character; a write wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            txc_r <= '0;
            rxc_r <= '0;
            rtc_r <= '0;
            div_low_r <= `SST_DIV_RESET;
            div_high_r <= `SST_DIV_RESET;
        end else begin
            if (rx_done && master) begin
                rxc_r.single_receive_enable <= 1'b0;
            end
            if (wr_lane0) begin
                if (woff == `SST_OFF_TX_CTRL) begin
                    txc_r <= wdata_r[`SST_TXC_W-1:0];
                end else if (woff == `SST_OFF_RX_CTRL) begin
                    rxc_r <= wdata_r[`SST_RXC_W-1:0];
                end else if (woff == `SST_OFF_RATE_CTRL) begin
                    rtc_r <= wdata_r[`SST_RTC_W-1:0];
                end else if (woff == `SST_OFF_DIV_LOW) begin
                    div_low_r <= wdata_r[7:0];
                end else if (woff == `SST_OFF_DIV_HIGH) begin
                    div_high_r <= wdata_r[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
    assign rd_take = s_axi_arvalid_in && !rvalid_r;
    assign roff = s_axi_araddr_in & `SST_WORD_MASK;
    assign rx_read = rd_take && roff == `SST_OFF_RX_DATA;

    // The shifter has no address; the buffer offset reads zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `SST_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= `SST_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            if (roff == `SST_OFF_TX_CTRL) begin
                rdata_r[`SST_TXC_W+1:0] <= {!hold_full_r, state_r == sst_pkg::SST_IDLE, txc_r};
            end else if (roff == `SST_OFF_RX_CTRL) begin
                rdata_r[`SST_RXC_W+1:0] <= {rx_ready_r, rx_ninth_r, rxc_r};
            end else if (roff == `SST_OFF_RATE_CTRL) begin
                rdata_r[`SST_RTC_W-1:0] <= rtc_r;
            end else if (roff == `SST_OFF_DIV_LOW) begin
                rdata_r[7:0] <= div_low_r;
            end else if (roff == `SST_OFF_DIV_HIGH) begin
                rdata_r[7:0] <= div_high_r;
            end else if (roff == `SST_OFF_RX_DATA) begin
                rdata_r[7:0] <= rx_data_r;
            end else if (roff != `SST_OFF_TX_BUF) begin
                rresp_r <= `SST_RESP_SLVERR;
            end
        end else if (s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || start_tx || start_rx) begin
            frame_edges_r <= 4'h0;
        end else if (trail_ev) begin
            frame_edges_r <= frame_edges_r + 4'h1;
        end
    end

    chk_half_duplex: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        data_pin_oe_out |-> !rx_mode)
        else $error("data pin driven in receive mode");
    chk_edge_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (trail_ev && last_bit && sync_on) |=>
            frame_edges_r == (txc_r.ninth_bit_enable ? `SST_BITS9 : `SST_BITS8))
        else $error("wrong clock count per character");
    chk_data_on_lead: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(data_pin_out) |-> $past(lead_ev))
        else $error("data changed off the leading edge");
    chk_idle_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == sst_pkg::SST_IDLE && $past(state_r) == sst_pkg::SST_IDLE && $stable(pol))
            |-> clock_pin_out == pol)
        else $error("clock idle level wrong");
    chk_tx_pins_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tx_mode && master) |-> (clock_pin_oe_out && data_pin_oe_out))
        else $error("master transmit pins not driven");
    chk_hold_waits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == sst_pkg::SST_SHIFT && hold_full_r && !(trail_ev && last_bit)) |=> hold_full_r)
        else $error("buffer moved while shifter busy");
    chk_load_at_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == sst_pkg::SST_IDLE && tx_mode && hold_full_r) |=>
            state_r == sst_pkg::SST_SHIFT ##0 (!hold_full_r || $past(buf_write)))
        else $error("buffer not loaded into empty shifter");
    chk_port_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sync_on |-> (!clock_pin_oe_out && !data_pin_oe_out) ##1 state_r == sst_pkg::SST_IDLE)
        else $error("disabled port still active");
    chk_slave_clock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !master |-> !clock_pin_oe_out)
        else $error("slave drives the clock pin");
    chk_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        buf_write |=> hold_full_r [*1])
        else $error("empty flag not cleared by write");
endmodule

// file: verification/sst_far_model.sv
// Far-side synchronous serial node: samples trailing edges and can supply the clock
`timescale 1ns/1ns
module sst_far_model (
    input wire logic clk_w_in,
    input wire logic clk_drv_in,
    input wire logic data_w_in,
    input wire logic pol_in,
    input wire logic listen_in,
    input wire logic gen_in,
    input wire logic [3:0] nbits_in,
    output logic clk_out,
    output logic [8:0] char_out,
    output logic [15:0] char_cnt_out,
    output logic [15:0] edge_cnt_out,
    output logic [7:0] viol_out
);
    logic [8:0] sh = 9'h0;
    logic [3:0] cnt = 4'h0;
    logic drv_q = 1'b0;
    time t_lead = 0;
    initial begin
        clk_out = 1'b0;
        char_cnt_out = 16'h0;
        edge_cnt_out = 16'h0;
        viol_out = 8'h0;
    end
    // Late copy, so a line that only just became driven yields no edge
    always @(clk_drv_in) drv_q <= #1 clk_drv_in;
    always @(negedge listen_in) cnt = 4'h0;
    // Clock toggles only inside a frame, idle level between frames
    always @(posedge gen_in) begin
        #1537;
        repeat (nbits_in) begin
            #400 clk_out = ~pol_in;
            #400 clk_out = pol_in;
        end
    end
    // This node never drives the data line
    always @(clk_w_in) begin
        if (!listen_in || !clk_drv_in || !drv_q) begin
            cnt = 4'h0;
        end else if (clk_w_in !== pol_in) begin
            t_lead = $time;
        end else begin
            sh = {data_w_in, sh[8:1]};
            cnt = cnt + 4'h1;
            edge_cnt_out = edge_cnt_out + 16'h1;
            if (cnt == nbits_in) begin
                char_out = sh >> (4'h9 - nbits_in);
                cnt = 4'h0;
                char_cnt_out = char_cnt_out + 16'h1;
            end
        end
    end
    // Data may move just after a leading edge, then holds to the trailing edge
    always @(data_w_in) begin
        if (listen_in && drv_q && !gen_in && clk_w_in !== pol_in && $time - t_lead > 150)
            viol_out = viol_out + 8'h1;
    end
endmodule

// file: verification/tb_sync_serial_master_tx.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ns
`include "sst_consts.svh"
module tb_sync_serial_master_tx;
    logic clk_in = 1'b0, rst_n_in = 1'b0, pol = 1'b0, listen = 1'b0, gen = 1'b0, flt_r = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, ck_o, ck_oe, dt_o, dt_oe, m_clk;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] nbits = 4'h8;
    logic [8:0] m_char;
    logic [15:0] m_cnt, m_edges;
    logic [15:0] exp_edges = 16'h0;
    logic [7:0] m_viol;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [8:0] exp_c[$];
    integer seed;
    int error_cnt = 0;
    int total_checks = 0;
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) flt_r <= ~flt_r;
    // Released lines show a changing pattern, except the clock line, which carries the far model's clock while gen is set
    wire ck_w = ck_oe ? ck_o : (gen ? m_clk : flt_r);
    wire dt_w = dt_oe ? dt_o : ~flt_r;
    sst_sync_serial i_sst_sync_serial (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .clock_pin_in(ck_w), .clock_pin_out(ck_o),
        .clock_pin_oe_out(ck_oe), .data_pin_in(dt_w), .data_pin_out(dt_o),
        .data_pin_oe_out(dt_oe));
    sst_far_model i_sst_far_model (
        .clk_w_in(ck_w), .clk_drv_in(ck_oe | gen), .data_w_in(dt_w), .pol_in(pol),
        .listen_in(listen), .gen_in(gen), .nbits_in(nbits), .clk_out(m_clk),
        .char_out(m_char), .char_cnt_out(m_cnt), .edge_cnt_out(m_edges), .viol_out(m_viol));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ran_out();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic check(input logic [33:0] g, input logic [33:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Data of an error answer carries no meaning, so only its code is compared
    task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
        if (e[33:32] !== 2'b00) g[31:0] = e[31:0];
        check(g, e);
    endtask
    always @(negedge clk_in) begin
        if (bvalid && bready) check(34'(bresp), 34'(exp_b.pop_front()));
        if (rvalid && rready) chk_rd({rresp, rdata}, exp_r.pop_front());
    end
    always @(m_cnt) begin
        if (m_cnt != 16'h0) check(34'(m_char), 34'(exp_c.pop_front()));
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        int n;
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_in);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            n++;
            @(posedge clk_in);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb && n < 40);
        if (!tb) ran_out();
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ta, tr;
        int n;
        exp_r.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_in);
            ta = arvalid && arready;
            tr = rvalid;
            n++;
            @(posedge clk_in);
            if (ta) arvalid <= 1'b0;
        end while (!tr && n < 40);
        if (!tr) ran_out();
    endtask
    function automatic logic [31:0] txw(input logic m, input logic n9, input logic d9);
        sst_pkg::sst_tx_ctrl_t t;
        t = '{ninth_data_bit: d9, ninth_bit_enable: n9, transmit_enable: 1'b1,
              clock_source_master: m, clocked_mode: 1'b1};
        return {27'h0, t};
    endfunction
    task automatic send(input logic [8:0] c);
        exp_c.push_back(c);
        exp_edges = exp_edges + 16'(nbits);
        wr(`SST_OFF_TX_BUF, {24'h0, c[7:0]}, `SST_RESP_OKAY);
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; n < 3000 && exp_c.size() != 0; n++) @(posedge clk_in);
        if (exp_c.size() != 0) ran_out();
        repeat (4) @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h9f508e7c;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(`SST_OFF_TX_CTRL, 34'h60);
        check(34'({ck_oe, dt_oe}), 34'h0);
        rd(8'h1c, {`SST_RESP_SLVERR, 32'h0});
        wr(8'h1c, 32'h0, `SST_RESP_SLVERR);
        $display("test reset and map done");
        wr(`SST_OFF_DIV_LOW, 32'h3, `SST_RESP_OKAY);
        wr(`SST_OFF_DIV_HIGH, 32'h0, `SST_RESP_OKAY);
        wr(`SST_OFF_RX_CTRL, 32'h1, `SST_RESP_OKAY);
        wr(`SST_OFF_TX_CTRL, txw(1'b1, 1'b0, 1'b0), `SST_RESP_OKAY);
        check(34'({ck_oe, dt_oe, ck_w}), 34'h6);
        rd(`SST_OFF_TX_CTRL, 34'h67);
        for (int p = 0; p < 2; p++) begin
            listen <= 1'b0;
            pol <= p[0];
            wr(`SST_OFF_RATE_CTRL, {31'h0, p[0]}, `SST_RESP_OKAY);
            repeat (2) @(posedge clk_in);
            listen <= 1'b1;
            send(9'($random(seed) & 8'hff));
            send(9'($random(seed) & 8'hff));
            rd(`SST_OFF_TX_CTRL, 34'h07);
            wait_done();
            check(34'(ck_w), 34'(p[0]));
            rd(`SST_OFF_TX_CTRL, 34'h67);
        end
        rd(`SST_OFF_TX_BUF, 34'h0);
        $display("test master transmit done");
        nbits <= 4'h9;
        wr(`SST_OFF_TX_CTRL, txw(1'b1, 1'b1, 1'b1), `SST_RESP_OKAY);
        send({1'b1, 8'($random(seed))});
        wait_done();
        nbits <= 4'h8;
        wr(`SST_OFF_TX_CTRL, txw(1'b1, 1'b0, 1'b0), `SST_RESP_OKAY);
        $display("test ninth bit done");
        listen <= 1'b0;
        wr(`SST_OFF_RX_CTRL, 32'h3, `SST_RESP_OKAY);
        check(34'({ck_oe, dt_oe}), 34'h2);
        repeat (200) @(posedge clk_in);
        wr(`SST_OFF_RX_CTRL, 32'h0, `SST_RESP_OKAY);
        check(34'({ck_oe, dt_oe}), 34'h0);
        listen <= 1'b1;
        send(9'($random(seed) & 8'hff));
        repeat (100) @(posedge clk_in);
        check(34'({ck_oe, exp_c.size()}), 34'h1);
        wr(`SST_OFF_RX_CTRL, 32'h1, `SST_RESP_OKAY);
        wait_done();
        $display("test receive mode and disable done");
        listen <= 1'b0;
        pol <= 1'b0;
        wr(`SST_OFF_RATE_CTRL, 32'h0, `SST_RESP_OKAY);
        gen <= 1'b1;
        wr(`SST_OFF_TX_CTRL, txw(1'b0, 1'b0, 1'b0), `SST_RESP_OKAY);
        listen <= 1'b1;
        send(9'($random(seed) & 8'hff));
        check(34'({ck_oe, dt_oe}), 34'h1);
        wait_done();
        $display("test slave transmit done");
        check(34'(m_edges), 34'(exp_edges));
        check(34'(m_viol), 34'h0);
        print_verdict();
    end
endmodule
